/* File: src/aipc_pkg.sv */
// Purpose: Shared constants for the record path control block
// Assumes: 9-bit control words at 7-bit register addresses
// Notes: Timing counts derive from the 200 MHz reference clock

package aipc_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [6:0] AIPC_ADDR_PWR1 = 7'h01;
    localparam logic [6:0] AIPC_ADDR_PWR2 = 7'h02;
    localparam logic [6:0] AIPC_ADDR_ADC = 7'h0e;
    localparam logic [6:0] AIPC_ADDR_SPARE = 7'h2a;
    localparam logic [6:0] AIPC_ADDR_INCTL = 7'h2c;
    localparam logic [6:0] AIPC_ADDR_LVOL = 7'h2d;
    localparam logic [6:0] AIPC_ADDR_RVOL = 7'h2e;
    localparam logic [6:0] AIPC_ADDR_LBOOST = 7'h2f;
    localparam logic [6:0] AIPC_ADDR_RBOOST = 7'h30;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [8:0] AIPC_RST_PWR1 = 9'h000;
    localparam logic [8:0] AIPC_RST_PWR2 = 9'h000;
    localparam logic [8:0] AIPC_RST_ADC = 9'h100;
    localparam logic [8:0] AIPC_RST_SPARE = 9'h000;
    localparam logic [8:0] AIPC_RST_INCTL = 9'h033;
    localparam logic [7:0] AIPC_RST_VOL = 8'h10;
    localparam logic [8:0] AIPC_RST_BOOST = 9'h100;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int AIPC_B_MIC_BIAS_ON = 4;
    localparam int AIPC_B_LCONV_ON = 0;
    localparam int AIPC_B_RCONV_ON = 1;
    localparam int AIPC_B_LMIX_ON = 4;
    localparam int AIPC_B_RMIX_ON = 5;
    localparam int AIPC_B_LINV = 0;
    localparam int AIPC_B_RINV = 1;
    localparam int AIPC_B_OSR = 3;
    localparam int AIPC_B_CORNER_LO = 4;
    localparam int AIPC_B_CORNER_HI = 6;
    localparam int AIPC_B_DIV_HI = 5;
    localparam int AIPC_B_HPF_MODE = 7;
    localparam int AIPC_B_HPF_EN = 8;
    localparam int AIPC_B_SPARE_SIDE = 5;
    localparam int AIPC_B_SPARE_LO = 6;
    localparam int AIPC_B_SPARE_HI = 8;
    localparam int AIPC_B_BIAS_LEVEL = 8;
    localparam int AIPC_B_GAIN_HI = 5;
    localparam int AIPC_B_MUTE = 6;
    localparam int AIPC_B_ZC_EN = 7;
    localparam int AIPC_B_RELEASE = 8;
    localparam int AIPC_B_AUX_HI = 2;
    localparam int AIPC_B_LINE_LO = 4;
    localparam int AIPC_B_LINE_HI = 6;
    localparam int AIPC_B_EXTRA = 8;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned AIPC_CLK_MHZ = 200;
    localparam int unsigned AIPC_ZC_TIMEOUT_US = 10000;
    localparam int unsigned AIPC_ZC_TIMEOUT_CYCLES = AIPC_ZC_TIMEOUT_US * AIPC_CLK_MHZ;

    // Gain release state per channel
    typedef enum logic [1:0] {
        AIPC_UPD_IDLE = 2'b00,
        AIPC_UPD_WAIT = 2'b01,
        AIPC_UPD_ARMED = 2'b10
    } aipc_upd_e;

endpackage : aipc_pkg

/* File: src/aipc_record_ctrl.sv */
// Purpose: Record path control registers, gain release and sample polarity
// Assumes: Control port writes one 9-bit word per strobe; samples synchronous to ref_clk
// Notes: Analogue stages are steered by the registered control outputs
//
// Notes on behaviour
// - Written gains wait until a release strobe, which arms both channels at once.
// - With zero-cross gating on, pending gain applies at a crossing or on timeout.
// - Without a crossing, timeout applies gain one to two periods after release.
// - Boost bit 8, reset one, selects +20dB amp gain, else 0dB.
// - Amp mute disconnects amplifier output from the boost stage.
// - Aux gain bits 2:0: zero disconnects, 1..7 give -12dB..+6dB in 3dB steps.
// - Line pin gain bits 6:4 use the same coding, zero disconnects.
// - Spare output gain bits 8:6 same coding; bit 5 routes left or right.
// - Mixer power enables are bits 4 and 5 of second power word, reset off.
// - First power bit 4 enables mic bias; otherwise the output floats.
// - Input control bit 8 selects bias level, 0.9 or 0.65 of supply.
// - Converters powered by bits 0 and 1 of second power word, reset off.
// - Converter control bits 0 and 1 invert left and right samples.
// - Converter control bit 3 selects 64x (reset) or 128x oversampling.
// - DC block filter active after reset, bypassed only when enable cleared.
// - Bit 7 selects first order fixed corner or second order selectable corner.
// - Corner field low bits 5:4 also drive the clock output divider.
// - Sample path carries full 24-bit precision.
// - Each mixer sums amp, auxiliary, line pin and spare sources with own gains.
// - Volume bit 7 enables zero-cross gating; clear applies gain at release.
// - DC block enable is converter control bit 8, default one.
// - Release bit is not stored; reads return zero there.

`timescale 1ns/1ps

module aipc_record_ctrl
    import aipc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = AIPC_ZC_TIMEOUT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [6:0] reg_wr_addr,
    input wire logic [8:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [6:0] reg_rd_addr,
    output logic [8:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [23:0] left_sample_in,
    input wire logic [23:0] right_sample_in,
    output logic sample_out_valid,
    output logic [23:0] left_sample_out,
    output logic [23:0] right_sample_out,
    output logic [5:0] left_amp_gain,
    output logic [5:0] right_amp_gain,
    output logic left_amp_connect,
    output logic right_amp_connect,
    output logic left_amp_extra_gain,
    output logic right_amp_extra_gain,
    output logic [2:0] left_aux_mix_gain,
    output logic [2:0] right_aux_mix_gain,
    output logic [2:0] left_line_pin_mix_gain,
    output logic [2:0] right_line_pin_mix_gain,
    output logic [2:0] left_spare_mix_gain,
    output logic [2:0] right_spare_mix_gain,
    output logic left_mixer_power_on,
    output logic right_mixer_power_on,
    output logic mic_bias_output_oe,
    output logic mic_bias_level_select,
    output logic left_converter_power_on,
    output logic right_converter_power_on,
    output logic oversample_ratio_select,
    output logic dc_block_enable,
    output logic dc_block_mode_select,
    output logic [2:0] dc_block_corner_select,
    output logic [1:0] pll_output_divider
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [8:0] pwr1;
        logic [8:0] pwr2;
        logic [8:0] adc;
        logic [8:0] spare;
        logic [8:0] inctl;
        logic [1:0][7:0] vol;
        logic [1:0][8:0] boost;
        logic [1:0][5:0] gain;
        aipc_upd_e [1:0] st;
        logic [31:0] tcount;
        logic [1:0] sign;
        logic [8:0] rdata;
        logic [1:0][23:0] smp;
        logic svalid;
    } aipc_state_s;

    aipc_state_s cur;
    aipc_state_s next_cur;

    logic tick;
    logic release_wr;
    logic [1:0] xing;
    logic [1:0][23:0] smp_in;

    assign smp_in[0] = left_sample_in;
    assign smp_in[1] = right_sample_in;
    // Free-running period end; shared by both channels
    assign tick = (cur.tcount == TIMEOUT_CYCLES - 1);
    // Release bit only acts as a strobe, it has no storage
    assign release_wr = reg_wr && reg_wdata[AIPC_B_RELEASE]
        && (reg_wr_addr == AIPC_ADDR_LVOL || reg_wr_addr == AIPC_ADDR_RVOL);

    // Crossing seen when the sign flips between consecutive samples
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            xing[i] = sample_valid && (smp_in[i][23] != cur.sign[i]);
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_cur = cur;
        next_cur.tcount = tick ? 32'h0000_0000 : cur.tcount + 32'h0000_0001;

        // Register writes
        if (reg_wr) begin
            case (reg_wr_addr)
                AIPC_ADDR_PWR1: next_cur.pwr1 = reg_wdata;
                AIPC_ADDR_PWR2: next_cur.pwr2 = reg_wdata;
                AIPC_ADDR_ADC: next_cur.adc = reg_wdata;
                AIPC_ADDR_SPARE: next_cur.spare = reg_wdata;
                AIPC_ADDR_INCTL: next_cur.inctl = reg_wdata;
                AIPC_ADDR_LVOL: next_cur.vol[0] = reg_wdata[7:0];
                AIPC_ADDR_RVOL: next_cur.vol[1] = reg_wdata[7:0];
                AIPC_ADDR_LBOOST: next_cur.boost[0] = reg_wdata;
                AIPC_ADDR_RBOOST: next_cur.boost[1] = reg_wdata;
                default: next_cur.pwr1 = cur.pwr1; // Unmapped writes are dropped
            endcase
        end

        // Gain release per channel; a new release restarts the wait
        for (int i = 0; i < 2; i++) begin
            if (sample_valid) begin
                next_cur.sign[i] = smp_in[i][23];
            end
            case (cur.st[i])
                AIPC_UPD_IDLE: begin
                    next_cur.st[i] = AIPC_UPD_IDLE;
                end
                AIPC_UPD_WAIT, AIPC_UPD_ARMED: begin
                    if (!cur.vol[i][AIPC_B_ZC_EN]) begin
                        next_cur.gain[i] = cur.vol[i][AIPC_B_GAIN_HI:0];
                        next_cur.st[i] = AIPC_UPD_IDLE;
                    end else if (xing[i]) begin
                        next_cur.gain[i] = cur.vol[i][AIPC_B_GAIN_HI:0];
                        next_cur.st[i] = AIPC_UPD_IDLE;
                    end else if (tick && cur.st[i] == AIPC_UPD_ARMED) begin
                        // Second period end after release forces the update
                        next_cur.gain[i] = cur.vol[i][AIPC_B_GAIN_HI:0];
                        next_cur.st[i] = AIPC_UPD_IDLE;
                    end else if (tick) begin
                        next_cur.st[i] = AIPC_UPD_ARMED;
                    end
                end
                default: next_cur.st[i] = AIPC_UPD_IDLE;
            endcase
            // Release comes last so it restarts the wait even in an apply cycle
            if (release_wr) begin
                next_cur.st[i] = AIPC_UPD_WAIT;
            end
        end

        // Sample polarity at full width
        next_cur.svalid = sample_valid;
        if (sample_valid) begin
            next_cur.smp[0] = cur.adc[AIPC_B_LINV] ? 24'h00_0000 - smp_in[0] : smp_in[0];
            next_cur.smp[1] = cur.adc[AIPC_B_RINV] ? 24'h00_0000 - smp_in[1] : smp_in[1];
        end

        // Read port; the release bit always reads zero
        if (reg_rd) begin
            case (reg_rd_addr)
                AIPC_ADDR_PWR1: next_cur.rdata = cur.pwr1;
                AIPC_ADDR_PWR2: next_cur.rdata = cur.pwr2;
                AIPC_ADDR_ADC: next_cur.rdata = cur.adc;
                AIPC_ADDR_SPARE: next_cur.rdata = cur.spare;
                AIPC_ADDR_INCTL: next_cur.rdata = cur.inctl;
                AIPC_ADDR_LVOL: next_cur.rdata = {1'b0, cur.vol[0]};
                AIPC_ADDR_RVOL: next_cur.rdata = {1'b0, cur.vol[1]};
                AIPC_ADDR_LBOOST: next_cur.rdata = cur.boost[0];
                AIPC_ADDR_RBOOST: next_cur.rdata = cur.boost[1];
                default: next_cur.rdata = 9'h000;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.pwr1 <= AIPC_RST_PWR1;
            cur.pwr2 <= AIPC_RST_PWR2;
            cur.adc <= AIPC_RST_ADC;
            cur.spare <= AIPC_RST_SPARE;
            cur.inctl <= AIPC_RST_INCTL;
            cur.vol[0] <= AIPC_RST_VOL;
            cur.vol[1] <= AIPC_RST_VOL;
            cur.gain[0] <= AIPC_RST_VOL[AIPC_B_GAIN_HI:0];
            cur.gain[1] <= AIPC_RST_VOL[AIPC_B_GAIN_HI:0];
            cur.boost[0] <= AIPC_RST_BOOST;
            cur.boost[1] <= AIPC_RST_BOOST;
            cur.st[0] <= AIPC_UPD_IDLE;
            cur.st[1] <= AIPC_UPD_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // Outputs, all straight from state
    // ****************************************
    // Gains and mixer source selects, four sources per mixer (amp, aux, line pin, spare)
    assign left_amp_gain = cur.gain[0];
    assign right_amp_gain = cur.gain[1];
    assign left_amp_connect = !cur.vol[0][AIPC_B_MUTE];
    assign right_amp_connect = !cur.vol[1][AIPC_B_MUTE];
    assign left_amp_extra_gain = cur.boost[0][AIPC_B_EXTRA];
    assign right_amp_extra_gain = cur.boost[1][AIPC_B_EXTRA];
    assign left_aux_mix_gain = cur.boost[0][AIPC_B_AUX_HI:0];
    assign right_aux_mix_gain = cur.boost[1][AIPC_B_AUX_HI:0];
    assign left_line_pin_mix_gain = cur.boost[0][AIPC_B_LINE_HI:AIPC_B_LINE_LO];
    assign right_line_pin_mix_gain = cur.boost[1][AIPC_B_LINE_HI:AIPC_B_LINE_LO];
    // Unselected side sees code zero, which is the disconnected setting
    assign left_spare_mix_gain = cur.spare[AIPC_B_SPARE_SIDE] ? cur.spare[AIPC_B_SPARE_HI:AIPC_B_SPARE_LO]
        : 3'h0;
    assign right_spare_mix_gain = cur.spare[AIPC_B_SPARE_SIDE] ? 3'h0
        : cur.spare[AIPC_B_SPARE_HI:AIPC_B_SPARE_LO];
    // Power and bias
    assign left_mixer_power_on = cur.pwr2[AIPC_B_LMIX_ON];
    assign right_mixer_power_on = cur.pwr2[AIPC_B_RMIX_ON];
    assign mic_bias_output_oe = cur.pwr1[AIPC_B_MIC_BIAS_ON];
    assign mic_bias_level_select = cur.inctl[AIPC_B_BIAS_LEVEL];
    assign left_converter_power_on = cur.pwr2[AIPC_B_LCONV_ON];
    assign right_converter_power_on = cur.pwr2[AIPC_B_RCONV_ON];
    // Converter filter controls; corner and divider cannot be set apart
    assign oversample_ratio_select = cur.adc[AIPC_B_OSR];
    assign dc_block_enable = cur.adc[AIPC_B_HPF_EN];
    assign dc_block_mode_select = cur.adc[AIPC_B_HPF_MODE];
    assign dc_block_corner_select = cur.adc[AIPC_B_CORNER_HI:AIPC_B_CORNER_LO];
    assign pll_output_divider = cur.adc[AIPC_B_DIV_HI:AIPC_B_CORNER_LO];
    assign reg_rdata = cur.rdata;
    assign sample_out_valid = cur.svalid;
    assign left_sample_out = cur.smp[0];
    assign right_sample_out = cur.smp[1];

    // ****************************************
    // Assertions
    // ****************************************
    default clocking aipc_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_GAIN_ONLY_ON_RELEASE: assert property (
        $changed(left_amp_gain) |-> $past(cur.st[0]) != AIPC_UPD_IDLE)
        else $error("left gain moved without a release");
    AST_ZC_GATE_HOLDS: assert property (
        cur.st[0] == AIPC_UPD_WAIT && cur.vol[0][AIPC_B_ZC_EN] && !xing[0] && !tick && !release_wr
        |=> $stable(left_amp_gain) && cur.st[0] == AIPC_UPD_WAIT)
        else $error("gated gain applied without crossing");
    AST_TIMEOUT_APPLY: assert property (
        cur.st[1] == AIPC_UPD_ARMED && tick && !release_wr
        |=> cur.st[1] == AIPC_UPD_IDLE && right_amp_gain == $past(cur.vol[1][AIPC_B_GAIN_HI:0]))
        else $error("timeout did not force update");
    AST_EXTRA_GAIN_WRITE: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_LBOOST |=> left_amp_extra_gain == $past(reg_wdata[AIPC_B_EXTRA]))
        else $error("extra gain bit not taken");
    AST_MUTE_DISCONNECT: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_RVOL && reg_wdata[AIPC_B_MUTE] |=> !right_amp_connect)
        else $error("mute did not disconnect");
    AST_SPARE_ROUTE: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_SPARE && reg_wdata[AIPC_B_SPARE_SIDE]
        |=> right_spare_mix_gain == 3'h0 && left_spare_mix_gain == $past(reg_wdata[8:6]))
        else $error("spare path misrouted");
    AST_BIAS_ENABLE: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_PWR1 |=> mic_bias_output_oe == $past(reg_wdata[AIPC_B_MIC_BIAS_ON]))
        else $error("bias enable not taken");
    AST_INVERT_SAMPLE: assert property (
        sample_valid && cur.adc[AIPC_B_LINV] |=> sample_out_valid && left_sample_out == 24'h00_0000 - $past(left_sample_in))
        else $error("left sample not inverted");
    AST_DIVIDER_TIED: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_ADC |=> pll_output_divider == $past(reg_wdata[5:4])
        && dc_block_corner_select == $past(reg_wdata[6:4]))
        else $error("divider and corner disagree");
    AST_NOZC_IMMEDIATE: assert property (
        cur.st[0] == AIPC_UPD_WAIT && !cur.vol[0][AIPC_B_ZC_EN] && !release_wr
        |=> cur.st[0] == AIPC_UPD_IDLE && left_amp_gain == $past(cur.vol[0][AIPC_B_GAIN_HI:0]))
        else $error("ungated gain not applied");
    AST_RELEASE_READS_ZERO: assert property (
        reg_rd && reg_rd_addr == AIPC_ADDR_LVOL |=> reg_rdata[AIPC_B_RELEASE] == 1'b0)
        else $error("release bit read back");
    // Control fields follow their register write one cycle later
    AST_MIX_GAIN_WRITE: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_LBOOST
        |=> left_aux_mix_gain == $past(reg_wdata[2:0]) && left_line_pin_mix_gain == $past(reg_wdata[6:4]))
        else $error("boost mix gains not taken");
    AST_MIXER_POWER: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_PWR2 |=> right_mixer_power_on == $past(reg_wdata[AIPC_B_RMIX_ON]))
        else $error("mixer power not taken");
    AST_CONVERTER_POWER: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_PWR2 |=> left_converter_power_on == $past(reg_wdata[AIPC_B_LCONV_ON]))
        else $error("converter power not taken");
    AST_BIAS_LEVEL: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_INCTL |=> mic_bias_level_select == $past(reg_wdata[AIPC_B_BIAS_LEVEL]))
        else $error("bias level not taken");
    AST_OSR_SELECT: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_ADC |=> oversample_ratio_select == $past(reg_wdata[AIPC_B_OSR]))
        else $error("oversample select not taken");
    AST_HPF_ENABLE: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_ADC |=> dc_block_enable == $past(reg_wdata[AIPC_B_HPF_EN]))
        else $error("filter enable not taken");
    AST_HPF_MODE: assert property (
        reg_wr && reg_wr_addr == AIPC_ADDR_ADC |=> dc_block_mode_select == $past(reg_wdata[AIPC_B_HPF_MODE]))
        else $error("filter mode not taken");
    // Release arms both channels; plain samples pass through at full width
    AST_BOTH_RELEASE: assert property (
        release_wr |=> cur.st[0] == AIPC_UPD_WAIT && cur.st[1] == AIPC_UPD_WAIT)
        else $error("release did not arm both channels");
    AST_SAMPLE_PASS: assert property (
        sample_valid && !cur.adc[AIPC_B_LINV] |=> left_sample_out == $past(left_sample_in))
        else $error("left sample not passed at full width");

    COV_ZC_APPLY: cover property (cur.st[0] == AIPC_UPD_WAIT && cur.vol[0][AIPC_B_ZC_EN] && xing[0]);
    COV_TIMEOUT_APPLY: cover property (cur.st[1] == AIPC_UPD_ARMED && tick && !xing[1]);
    COV_IMMEDIATE_APPLY: cover property (release_wr ##1 cur.st[0] == AIPC_UPD_WAIT && !cur.vol[0][AIPC_B_ZC_EN]);
    COV_INVERTED: cover property (sample_valid && cur.adc[AIPC_B_RINV]);
    COV_MUTED_RELEASE: cover property (release_wr && !left_amp_connect);

endmodule : aipc_record_ctrl

/* File: test/adc_input_path_control_test.sv */
// Purpose: Self-checking bench for the record path control block
// Assumes: Short timeout parameter of 16 cycles
// Notes: Each scenario drives the block and judges its own results

`timescale 1ns/1ps

// ****************************************
// Bench top
// ****************************************
module adc_input_path_control_test;
    import aipc_pkg::*;
    localparam int unsigned TO = 16;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [6:0] reg_wr_addr = 7'h0;
    logic [8:0] reg_wdata = 9'h0;
    logic reg_rd = 1'b0;
    logic [6:0] reg_rd_addr = 7'h0;
    logic [8:0] reg_rdata;
    logic sample_valid, sample_out_valid;
    logic [23:0] left_sample_in, right_sample_in, left_sample_out, right_sample_out;
    logic [5:0] left_amp_gain, right_amp_gain;
    logic left_amp_connect, right_amp_connect, left_amp_extra_gain, right_amp_extra_gain;
    logic [2:0] left_aux_mix_gain, right_aux_mix_gain, left_line_pin_mix_gain;
    logic [2:0] right_line_pin_mix_gain, left_spare_mix_gain, right_spare_mix_gain;
    logic left_mixer_power_on, right_mixer_power_on, mic_bias_output_oe, mic_bias_level_select;
    logic left_converter_power_on, right_converter_power_on, oversample_ratio_select;
    logic dc_block_enable, dc_block_mode_select;
    logic [2:0] dc_block_corner_select;
    logic [1:0] pll_output_divider;
    int miscompares = 0;
    int n_checks = 0;

    // Short timeout keeps the fallback path inside a few dozen cycles
    aipc_record_ctrl #(.TIMEOUT_CYCLES(TO)) dut (.ref_clk, .rst, .reg_wr, .reg_wr_addr,
        .reg_wdata, .reg_rd, .reg_rd_addr, .reg_rdata, .sample_valid, .left_sample_in,
        .right_sample_in, .sample_out_valid, .left_sample_out, .right_sample_out,
        .left_amp_gain, .right_amp_gain, .left_amp_connect, .right_amp_connect,
        .left_amp_extra_gain, .right_amp_extra_gain, .left_aux_mix_gain, .right_aux_mix_gain,
        .left_line_pin_mix_gain, .right_line_pin_mix_gain, .left_spare_mix_gain,
        .right_spare_mix_gain, .left_mixer_power_on, .right_mixer_power_on,
        .mic_bias_output_oe, .mic_bias_level_select, .left_converter_power_on,
        .right_converter_power_on, .oversample_ratio_select, .dc_block_enable,
        .dc_block_mode_select, .dc_block_corner_select, .pll_output_divider);
    aipc_source_model src (.ref_clk, .sample_valid, .left_sample_in, .right_sample_in);

    always #2.5 ref_clk = ~ref_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b1;
        reg_wr_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    // Read answer lands on the edge after the strobe
    task automatic rd_chk(input logic [6:0] a, input logic [8:0] e);
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b1;
        reg_rd_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        chk("reg_rdata", e, reg_rdata);
    endtask : rd_chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wait_n

    task automatic t_reset();
        chk("lgain", AIPC_RST_VOL[5:0], left_amp_gain);
        chk("lextra", 1'b1, left_amp_extra_gain);
        chk("hpf_en", 1'b1, dc_block_enable);
        chk("bias_oe", 1'b0, mic_bias_output_oe);
        chk("pwr", 4'h0, {left_mixer_power_on, right_mixer_power_on,
            left_converter_power_on, right_converter_power_on});
        rd_chk(AIPC_ADDR_ADC, 9'h100);
        rd_chk(AIPC_ADDR_RBOOST, 9'h100);
        rd_chk(AIPC_ADDR_PWR2, 9'h000);
        rd_chk(7'h7f, 9'h000);
    endtask : t_reset

    task automatic t_controls();
        wr(AIPC_ADDR_PWR1, 9'h010);
        wr(AIPC_ADDR_PWR2, 9'h033);
        wr(AIPC_ADDR_ADC, 9'h0fb);
        wr(AIPC_ADDR_INCTL, 9'h100);
        wr(AIPC_ADDR_LBOOST, 9'h075);
        wr(AIPC_ADDR_SPARE, 9'h1e0);
        wait_n(1);
        chk("bias_oe", 1'b1, mic_bias_output_oe);
        chk("bias_lvl", 1'b1, mic_bias_level_select);
        chk("pwr", 4'hf, {left_mixer_power_on, right_mixer_power_on,
            left_converter_power_on, right_converter_power_on});
        chk("osr", 1'b1, oversample_ratio_select);
        chk("hpf", 3'h2, {dc_block_enable, dc_block_mode_select, 1'b0});
        chk("corner", 3'h7, dc_block_corner_select);
        chk("div", 2'h3, pll_output_divider);
        chk("lmix", 7'h3d, {left_amp_extra_gain, left_line_pin_mix_gain,
            left_aux_mix_gain});
        chk("rmix", 7'h40, {right_amp_extra_gain, right_line_pin_mix_gain,
            right_aux_mix_gain});
        chk("spare", 6'h38, {left_spare_mix_gain, right_spare_mix_gain});
        wr(AIPC_ADDR_SPARE, 9'h0c0);
        wait_n(1);
        chk("spare", 6'h03, {left_spare_mix_gain, right_spare_mix_gain});
        rd_chk(AIPC_ADDR_LBOOST, 9'h075);
    endtask : t_controls

    task automatic t_release();
        wr(AIPC_ADDR_LVOL, 9'h05f);
        wait_n(2);
        chk("lgain", 6'h10, left_amp_gain);
        chk("lconn", 1'b0, left_amp_connect);
        wr(AIPC_ADDR_RVOL, 9'h16a);
        wait_n(1);
        chk("lgain", 6'h1f, left_amp_gain);
        chk("rgain", 6'h2a, right_amp_gain);
        chk("rconn", 1'b0, right_amp_connect);
        rd_chk(AIPC_ADDR_RVOL, 9'h06a);
        rd_chk(AIPC_ADDR_LVOL, 9'h05f);
    endtask : t_release

    // Left sees a sign change, right stays positive and must keep its gain
    task automatic t_zero_cross();
        wr(AIPC_ADDR_LVOL, 9'h085);
        wr(AIPC_ADDR_RVOL, 9'h095);
        wr(AIPC_ADDR_LVOL, 9'h185);
        src.send(24'h000100, 24'h000100);
        wait_n(2);
        chk("lgain", 6'h1f, left_amp_gain);
        src.send(24'hfff000, 24'h000200);
        wait_n(1);
        chk("lgain", 6'h05, left_amp_gain);
        chk("rgain", 6'h2a, right_amp_gain);
        chk("rconn", 1'b1, right_amp_connect);
    endtask : t_zero_cross

    task automatic t_timeout();
        int n;
        n = 0;
        wr(AIPC_ADDR_RVOL, 9'h1b3);
        while (right_amp_gain !== 6'h33 && n < 3 * TO) begin
            wait_n(1);
            n++;
        end
        chk("timeout_ok", 1'b1, n >= TO && n <= 2 * TO + 2);
    endtask : t_timeout

    task automatic t_samples();
        wr(AIPC_ADDR_ADC, 9'h103);
        src.send(24'h000001, 24'h800000);
        chk("svalid", 1'b1, sample_out_valid);
        chk("lout", 24'hffffff, left_sample_out);
        chk("rout", 24'h800000, right_sample_out);
        wr(AIPC_ADDR_ADC, 9'h102);
        src.send(24'h123456, 24'h000002);
        chk("lout", 24'h123456, left_sample_out);
        chk("rout", 24'hfffffe, right_sample_out);
        wait_n(1);
        chk("svalid", 1'b0, sample_out_valid);
    endtask : t_samples

    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_controls();
        t_release();
        t_zero_cross();
        t_timeout();
        t_samples();
        finish_test();
    end
endmodule : adc_input_path_control_test

/* File: test/aipc_source_model.sv */
// Purpose: Stand-in for the analogue sources feeding the record path samples
// Assumes: One sample pair per strobe, launched just after a rising edge
// Notes: Between strobes the sample lines show the inverse of the last pair

`timescale 1ns/1ps

// ****************************************
// Source model
// ****************************************
module aipc_source_model (
    input wire logic ref_clk,
    output logic sample_valid,
    output logic [23:0] left_sample_in,
    output logic [23:0] right_sample_in
);
    initial begin
        sample_valid = 1'b0;
        left_sample_in = 24'h0;
        right_sample_in = 24'h0;
    end

    // One strobed pair; lines then stop showing the old value so stale use shows
    task automatic send(input logic [23:0] l, input logic [23:0] r);
        @(posedge ref_clk);
        #1;
        sample_valid = 1'b1;
        left_sample_in = l;
        right_sample_in = r;
        @(posedge ref_clk);
        #1;
        sample_valid = 1'b0;
        left_sample_in = ~l;
        right_sample_in = ~r;
    endtask : send
endmodule : aipc_source_model
